// *** core/sfp_bit_collect.sv ***
/*
  Bit collector: counts the bits of one frame, keeps its first 48 bits and its
  last 5 bits, and pulses done with the frame's length after the last bit.
  Assumes the caller only presents bits it has accepted.
*/
`timescale 1ns/1ps
`default_nettype none

module sfp_bit_collect (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Accepted bits
  input wire logic bit_valid,
  input wire logic bit_data,
  input wire logic bit_last,
  // Collected frame
  output logic done_q,
  output logic [47:0] head_q,
  output logic [4:0] tail_q,
  output logic [11:0] len_q,
  output logic over_q
);

  logic [11:0] count_q;
  logic over_run_q;
  logic [11:0] count_d;

  assign count_d = count_q + 12'h001;

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter and overlength flag of the frame in progress
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      count_q <= 12'h000;
      over_run_q <= 1'b0;
    end
    else if (bit_valid)
    begin
      count_q <= bit_last ? 12'h000 : count_d;
      over_run_q <= bit_last ? 1'b0 : (over_run_q | (count_q >= sfp_pkg::LEN_MAX));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Head and tail windows, first bit lands in the top of head
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      head_q <= 48'h0000_0000_0000;
      tail_q <= 5'h00;
    end
    else if (bit_valid)
    begin
      if (count_q < 12'(sfp_pkg::HEAD_BITS))
      begin
        head_q[6'(sfp_pkg::HEAD_BITS - 1) - count_q[5:0]] <= bit_data;
      end
      tail_q <= {tail_q[3:0], bit_data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // End of frame report
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      done_q <= 1'b0;
      len_q <= 12'h000;
      over_q <= 1'b0;
    end
    else
    begin
      done_q <= bit_valid & bit_last;
      if (bit_valid && bit_last)
      begin
        len_q <= count_d;
        over_q <= over_run_q | (count_q >= sfp_pkg::LEN_MAX);
      end
    end
  end

endmodule

`default_nettype wire

// *** core/sfp_parser.sv ***
/*
  Speech frame field parser: takes coded frames bit-serially, identifies the
  layout from the frame length and the leading flags, and presents the decoded
  signalling fields. Status and control through an Avalon-MM slave.
  Assumes the source marks the last bit of each frame and honours in_ready.
*/
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module sfp_parser (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Frame bit stream
  input wire logic in_valid,
  input wire logic in_bit,
  input wire logic in_last,
  output logic in_ready,
  // Decoded result
  output logic res_valid,
  output logic res_err,
  output var sfp_pkg::sfp_kind_e res_kind,
  output var sfp_pkg::sfp_core_e res_core,
  output logic [1:0] res_bw,
  output logic [3:0] res_ctype,
  output logic res_prev_lp,
  output logic res_int16k,
  output logic res_fd_ext,
  // Silence descriptor fields
  output logic [6:0] res_sid_gain,
  output logic [36:0] res_sid_env,
  output logic [2:0] res_sid_hang,
  output logic [5:0] res_sid_extra,
  // Channel-aware fields
  output logic [4:0] res_ca_index,
  output logic res_rf_active,
  output logic [2:0] res_rf_offset,
  output var sfp_pkg::sfp_rtype_e res_rf_type,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Field of w bits starting at pos, first bit most significant
  function automatic logic [7:0] fld(input logic [47:0] h, input int pos, input int w);
    logic [47:0] s;
    s = h >> (48 - pos - w);
    fld = s[7:0] & 8'((1 << w) - 1);
  endfunction

  // Offset code to frame count
  function automatic logic [2:0] rf_frames(input logic [1:0] code);
    case (code)
      2'h0: rf_frames = 3'h2;
      2'h1: rf_frames = 3'h3;
      2'h2: rf_frames = 3'h5;
      default: rf_frames = 3'h7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Collector

  logic enable_q;
  logic done;
  logic [47:0] head;
  logic [4:0] tail;
  logic [11:0] len;
  logic over;

  assign in_ready = enable_q;

  sfp_bit_collect u_collect (
    .mclk(mclk),
    .nrst(nrst),
    .bit_valid(in_valid & in_ready),
    .bit_data(in_bit),
    .bit_last(in_last),
    .done_q(done),
    .head_q(head),
    .tail_q(tail),
    .len_q(len),
    .over_q(over)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Layout decode

  logic ok_d;
  sfp_pkg::sfp_kind_e kind_d;
  sfp_pkg::sfp_core_e core_d;
  logic [1:0] bw_d;
  logic [3:0] ctype_d;
  logic prev_lp_d;
  logic int16k_d;
  logic fd_ext_d;
  logic [6:0] gain_d;
  logic [36:0] env_d;
  logic [2:0] hang_d;
  logic [5:0] extra_d;
  logic [4:0] ca_index_d;
  logic rf_active_d;
  logic [2:0] rf_offset_d;
  sfp_pkg::sfp_rtype_e rf_type_d;

  // Shared high-quality transform tail
  logic hq_prev;
  logic hq_rate;
  assign hq_prev = head[47 - sfp_pkg::POS_PREV_LP];
  assign hq_rate = head[47 - sfp_pkg::POS_HQ_RATE];

  always_comb
  begin
    ok_d = !over;
    kind_d = sfp_pkg::KIND_RATE;
    core_d = sfp_pkg::CORE_NONE;
    bw_d = 2'h0;
    ctype_d = 4'h0;
    prev_lp_d = 1'b0;
    int16k_d = 1'b0;
    fd_ext_d = 1'b0;
    gain_d = 7'h00;
    env_d = 37'h0;
    hang_d = 3'h0;
    extra_d = 6'h00;
    ca_index_d = 5'h00;
    rf_active_d = 1'b0;
    rf_offset_d = 3'h0;
    rf_type_d = sfp_pkg::RTYPE_EMPTY;
    if (len == sfp_pkg::LEN_32K)
    begin
      if (!head[47 - sfp_pkg::POS_CORE_FLAG])
      begin
        core_d = sfp_pkg::CORE_PREDICTIVE;
        ctype_d = 4'(fld(head, sfp_pkg::POS_JOINT, sfp_pkg::W_JOINT));
      end
      else if (head[47 - sfp_pkg::POS_MDCT_SEL])
      begin
        core_d = sfp_pkg::CORE_TRANSFORM_EXC;
        ctype_d = {2'h0, 2'(fld(head, sfp_pkg::POS_TRANSFORM_CODER_TYPE, 2))};
      end
      else
      begin
        core_d = sfp_pkg::CORE_HQ_TRANSFORM;
        prev_lp_d = hq_prev;
        int16k_d = hq_prev & hq_rate;
      end
    end
    else if (len == sfp_pkg::LEN_48K || len == sfp_pkg::LEN_96K || len == sfp_pkg::LEN_128K)
    begin
      core_d = sfp_pkg::CORE_TRANSFORM_EXC;
      bw_d = 2'(fld(head, sfp_pkg::POS_WIDE_BW, 2));
      ctype_d = {1'b0, 3'(fld(head, sfp_pkg::POS_WIDE_TRANSFORM_CODER_TYPE, 3))};
    end
    else if (len == sfp_pkg::LEN_64K)
    begin
      if (!head[47 - sfp_pkg::POS_CORE_FLAG])
      begin
        core_d = sfp_pkg::CORE_PREDICTIVE;
        ctype_d = 4'(fld(head, sfp_pkg::POS_JOINT, sfp_pkg::W_JOINT));
        fd_ext_d = 1'b1;
      end
      else
      begin
        core_d = sfp_pkg::CORE_HQ_TRANSFORM;
        prev_lp_d = head[47 - sfp_pkg::POS_MDCT_SEL];
        int16k_d = head[47 - sfp_pkg::POS_MDCT_SEL] & hq_prev;
      end
    end
    else if (len == sfp_pkg::LEN_SID)
    begin
      if (!head[47 - sfp_pkg::POS_CN_KIND])
      begin
        kind_d = sfp_pkg::KIND_SID_SPECTRAL;
        bw_d = 2'(fld(head, sfp_pkg::POS_FD_BW, 2));
        int16k_d = head[47 - sfp_pkg::POS_FD_RATE];
        gain_d = 7'(fld(head, sfp_pkg::POS_FD_GAIN, 7));
        env_d = head[47 - sfp_pkg::POS_FD_ENERGY -: sfp_pkg::W_FD_ENERGY];
      end
      else
      begin
        kind_d = sfp_pkg::KIND_SID_PREDICTIVE;
        bw_d = {1'b0, head[47 - sfp_pkg::POS_LP_BW]};
        int16k_d = head[47 - sfp_pkg::POS_LP_RATE];
        hang_d = 3'(fld(head, sfp_pkg::POS_LP_HANG, 3));
        env_d = {8'h00, head[47 - sfp_pkg::POS_LP_PAIRS -: sfp_pkg::W_LP_PAIRS]};
        gain_d = 7'(fld(head, sfp_pkg::POS_LP_LBE, 7));
        // Wide: 6 envelope bits; super-wide: 4 energy bits then 2 unused
        extra_d = head[47 - sfp_pkg::POS_LP_TAIL -: 6] & (bw_d[0] ? 6'h3C : 6'h3F);
      end
    end
    else if (len == sfp_pkg::LEN_CA)
    begin
      kind_d = sfp_pkg::KIND_AWARE;
      ca_index_d = 5'(fld(head, 0, sfp_pkg::W_CA_INDEX));
      rf_active_d = ca_index_d[sfp_pkg::W_CA_INDEX - 1 - sfp_pkg::POS_CA_RF_FLAG];
      if (rf_active_d)
      begin
        rf_offset_d = rf_frames(tail[4:3]);
        rf_type_d = sfp_pkg::sfp_rtype_e'(tail[2:0]);
      end
      else if (tail != 5'h00)
      begin
        ok_d = 1'b0;
      end
    end
    else
    begin
      ok_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result registers: valid and error pulse once per frame, fields held until the next good frame

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      res_valid <= 1'b0;
      res_err <= 1'b0;
    end
    else
    begin
      res_valid <= done & ok_d;
      res_err <= done & !ok_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      res_kind <= sfp_pkg::KIND_RATE;
      res_core <= sfp_pkg::CORE_NONE;
      res_bw <= 2'h0;
      res_ctype <= 4'h0;
      res_prev_lp <= 1'b0;
      res_int16k <= 1'b0;
      res_fd_ext <= 1'b0;
      res_sid_gain <= 7'h00;
      res_sid_env <= 37'h0;
      res_sid_hang <= 3'h0;
      res_sid_extra <= 6'h00;
      res_ca_index <= 5'h00;
      res_rf_active <= 1'b0;
      res_rf_offset <= 3'h0;
      res_rf_type <= sfp_pkg::RTYPE_EMPTY;
    end
    else if (done && ok_d)
    begin
      res_kind <= kind_d;
      res_core <= core_d;
      res_bw <= bw_d;
      res_ctype <= ctype_d;
      res_prev_lp <= prev_lp_d;
      res_int16k <= int16k_d;
      res_fd_ext <= fd_ext_d;
      res_sid_gain <= gain_d;
      res_sid_env <= env_d;
      res_sid_hang <= hang_d;
      res_sid_extra <= extra_d;
      res_ca_index <= ca_index_d;
      res_rf_active <= rf_active_d;
      res_rf_offset <= rf_offset_d;
      res_rf_type <= rf_type_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait state on every access

  logic ack_q;
  logic [15:0] frame_cnt_q;
  logic [15:0] err_cnt_q;
  logic [11:0] last_len_q;
  logic clear_cmd;
  logic [31:0] rd_d;

  assign avs_waitrequest = (avs_read | avs_write) & !ack_q;
  assign clear_cmd = avs_write & ack_q & (avs_address == sfp_pkg::REG_CTRL) & avs_byteenable[0]
    & avs_writedata[sfp_pkg::CTRL_CLEAR];

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= (avs_read | avs_write) & !ack_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      enable_q <= sfp_pkg::CTRL_ENABLE_RST;
    end
    else if (avs_write && ack_q && avs_address == sfp_pkg::REG_CTRL && avs_byteenable[0])
    begin
      enable_q <= avs_writedata[sfp_pkg::CTRL_ENABLE];
    end
  end

  // A clear in the same cycle as a count leaves the counter at one
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      frame_cnt_q <= 16'h0000;
      err_cnt_q <= 16'h0000;
      last_len_q <= 12'h000;
    end
    else
    begin
      frame_cnt_q <= (clear_cmd ? 16'h0000 : frame_cnt_q) + {15'h0000, res_valid};
      err_cnt_q <= (clear_cmd ? 16'h0000 : err_cnt_q) + {15'h0000, res_err};
      if (done)
      begin
        last_len_q <= len;
      end
    end
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (avs_address == sfp_pkg::REG_CTRL)
    begin
      rd_d[sfp_pkg::CTRL_ENABLE] = enable_q;
    end
    else if (avs_address == sfp_pkg::REG_COUNT)
    begin
      rd_d = {err_cnt_q, frame_cnt_q};
    end
    else if (avs_address == sfp_pkg::REG_LAST)
    begin
      rd_d = {2'h0, res_int16k, res_prev_lp, res_fd_ext, res_bw, res_ctype, res_core, res_kind, 5'h00, last_len_q};
    end
    else if (avs_address == sfp_pkg::REG_AWARE)
    begin
      rd_d = {20'h00000, res_rf_active, res_rf_type, res_rf_offset, res_ca_index};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (avs_read && !ack_q)
    begin
      avs_readdata <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_done_len(logic [11:0] l);
    done && !over && len == l;
  endsequence

  a_core_select: assert property (@(posedge mclk) disable iff (!nrst)
    s_done_len(sfp_pkg::LEN_32K) ##0 !head[47] |=> res_valid && res_core == sfp_pkg::CORE_PREDICTIVE)
    else $error("predictive core not chosen at 32 kbps");
  a_joint_index: assert property (@(posedge mclk) disable iff (!nrst)
    s_done_len(sfp_pkg::LEN_32K) ##0 !head[47] |=> res_ctype == $past(head[46:43]))
    else $error("joint index not taken from bits 1 to 4");
  a_tcx_type: assert property (@(posedge mclk) disable iff (!nrst)
    s_done_len(sfp_pkg::LEN_32K) ##0 head[47:46] == 2'h3
    |=> res_core == sfp_pkg::CORE_TRANSFORM_EXC && res_ctype[1:0] == $past(head[45:44]))
    else $error("transform coder type wrong");
  a_hq_rate_gate: assert property (@(posedge mclk) disable iff (!nrst)
    s_done_len(sfp_pkg::LEN_32K) ##0 head[47:45] == 3'h4 |=> !res_int16k && !res_prev_lp)
    else $error("rate bit read without previous predictive frame");
  a_wide_tcx: assert property (@(posedge mclk) disable iff (!nrst)
    s_done_len(sfp_pkg::LEN_48K) |=> res_valid && res_core == sfp_pkg::CORE_TRANSFORM_EXC)
    else $error("48 kbps frame not transform excitation");
  a_sid_length: assert property (@(posedge mclk) disable iff (!nrst)
    res_valid && (res_kind == sfp_pkg::KIND_SID_SPECTRAL || res_kind == sfp_pkg::KIND_SID_PREDICTIVE)
    |-> $past(len) == sfp_pkg::LEN_SID)
    else $error("descriptor accepted at wrong length");
  a_sid_gain: assert property (@(posedge mclk) disable iff (!nrst)
    s_done_len(sfp_pkg::LEN_SID) ##0 !head[47] |=> res_sid_gain == $past(head[43:37]))
    else $error("global gain misplaced");
  a_sid_hang: assert property (@(posedge mclk) disable iff (!nrst)
    s_done_len(sfp_pkg::LEN_SID) ##0 head[47] |=> res_sid_hang == $past(head[44:42]))
    else $error("hangover counter misplaced");
  a_rf_type: assert property (@(posedge mclk) disable iff (!nrst)
    s_done_len(sfp_pkg::LEN_CA) ##0 head[43] |=> res_rf_active && res_rf_type == $past(tail[2:0]))
    else $error("redundancy type not from last three bits");
  a_bad_drop: assert property (@(posedge mclk) disable iff (!nrst)
    done && len == 12'h031 |=> res_err && !res_valid ##1 !res_err)
    else $error("bad length not flagged as one error pulse");

endmodule

`default_nettype wire

// *** core/sfp_pkg.sv ***
/*
  Shared constants and types of the speech frame field parser: frame lengths,
  field positions, register map and result encodings.
  Assumes frames arrive most significant bit first, one bit per clock at most.
*/
`default_nettype none

package sfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame lengths in bits
  localparam logic [11:0] LEN_SID = 12'h030;
  localparam logic [11:0] LEN_CA = 12'h108;
  localparam logic [11:0] LEN_32K = 12'h280;
  localparam logic [11:0] LEN_48K = 12'h3C0;
  localparam logic [11:0] LEN_64K = 12'h500;
  localparam logic [11:0] LEN_96K = 12'h780;
  localparam logic [11:0] LEN_128K = 12'hA00;
  localparam logic [11:0] LEN_MAX = 12'hA00;
  localparam int HEAD_BITS = 48;
  localparam int TAIL_BITS = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, counted from the first bit of the frame
  localparam int POS_CORE_FLAG = 0;
  localparam int POS_MDCT_SEL = 1;
  localparam int POS_JOINT = 1;
  localparam int W_JOINT = 4;
  localparam int POS_TRANSFORM_CODER_TYPE = 2;
  localparam int POS_PREV_LP = 2;
  localparam int POS_HQ_RATE = 3;
  localparam int POS_WIDE_BW = 1;
  localparam int POS_WIDE_TRANSFORM_CODER_TYPE = 3;
  localparam int POS_CN_KIND = 0;
  localparam int POS_FD_BW = 1;
  localparam int POS_FD_RATE = 3;
  localparam int POS_FD_GAIN = 4;
  localparam int POS_FD_ENERGY = 11;
  localparam int W_FD_ENERGY = 37;
  localparam int POS_LP_BW = 1;
  localparam int POS_LP_RATE = 2;
  localparam int POS_LP_HANG = 3;
  localparam int POS_LP_PAIRS = 6;
  localparam int W_LP_PAIRS = 29;
  localparam int POS_LP_LBE = 35;
  localparam int POS_LP_TAIL = 42;
  localparam int W_CA_INDEX = 5;
  localparam int POS_CA_RF_FLAG = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_COUNT = 5'h04;
  localparam logic [4:0] REG_LAST = 5'h08;
  localparam logic [4:0] REG_AWARE = 5'h0C;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_CLEAR = 1;
  localparam logic CTRL_ENABLE_RST = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Result encodings
  typedef enum logic [1:0] {KIND_RATE, KIND_SID_SPECTRAL, KIND_SID_PREDICTIVE, KIND_AWARE} sfp_kind_e;
  typedef enum logic [1:0] {CORE_NONE, CORE_PREDICTIVE, CORE_HQ_TRANSFORM, CORE_TRANSFORM_EXC} sfp_core_e;
  typedef enum logic [2:0] {
    RTYPE_EMPTY, RTYPE_TRANSFORM_FREQ, RTYPE_TRANSFORM_TIME1, RTYPE_TRANSFORM_TIME2,
    RTYPE_ALL_PREDICTED, RTYPE_UNPREDICTED, RTYPE_GENERIC_PREDICTED, RTYPE_NOISE_EXCITED
  } sfp_rtype_e;

endpackage

`default_nettype wire

// *** verif/sfp_src.sv ***
/*
  Frame source model: on go, sends one frame of len bits, first bit first.
  Assumes the parser's in_ready and the bench clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sfp_src (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bench control
  input wire logic go,
  input wire logic slow,
  input wire logic [11:0] len,
  input wire logic [47:0] head,
  input wire logic [4:0] tail,
  // Stream
  input wire logic in_ready,
  output logic in_valid,
  output logic in_bit,
  output logic in_last
);
  logic [11:0] idx_q = 12'h000;
  logic busy_q = 1'b0;
  logic gap_q = 1'b0;
  logic tog_q = 1'b0;

  assign in_valid = busy_q && !gap_q;
  assign in_last = in_valid && idx_q == len - 12'h001;
  // Idle line toggles so no stale bit survives
  assign in_bit = !in_valid ? tog_q : idx_q < 12'h030 ? head[6'(12'h02F - idx_q)] :
    idx_q >= len - 12'h005 ? tail[3'(len - 12'h001 - idx_q)] : idx_q[0] ^ idx_q[3];

  always_ff @(posedge mclk)
  begin
    tog_q <= !tog_q;
  end

  // Bit held until accepted; slow inserts a gap per bit
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      gap_q <= 1'b0;
      idx_q <= 12'h000;
    end
    else if (!busy_q)
    begin
      busy_q <= go;
      idx_q <= 12'h000;
    end
    else if (gap_q)
    begin
      gap_q <= 1'b0;
    end
    else if (in_ready)
    begin
      idx_q <= idx_q + 12'h001;
      gap_q <= slow;
      busy_q <= !in_last;
    end
  end
endmodule

`default_nettype wire

// *** verif/speech_frame_field_parser_tb.sv ***
/*
  Parser bench: table of rate frames and one channel-aware frame, then descriptor, channel-aware, error,
  register and reset cases. Assumes the sfp_src model drives the stream.
*/
`timescale 1ns/1ps
`default_nettype none

module speech_frame_field_parser_tb;
  typedef struct packed {logic [11:0] len; logic [47:0] head; logic [12:0] exp; logic [12:0] msk;} sfp_row_s;
  // Expected {kind, core, bw, ctype, prev_lp, int16k, fd_ext} under mask
  localparam sfp_row_s ROWS [10] = '{
    '{sfp_pkg::LEN_32K, 48'h5000_0000_0000, 13'h0250, 13'h1E78},
    '{sfp_pkg::LEN_32K, 48'hE000_0000_0000, 13'h0610, 13'h1E78},
    '{sfp_pkg::LEN_32K, 48'hB000_0000_0000, 13'h0406, 13'h1E06},
    '{sfp_pkg::LEN_32K, 48'h9000_0000_0000, 13'h0400, 13'h1E06},
    '{sfp_pkg::LEN_64K, 48'h3000_0000_0000, 13'h0231, 13'h1E79},
    '{sfp_pkg::LEN_64K, 48'hA000_0000_0000, 13'h0400, 13'h1E06},
    '{sfp_pkg::LEN_48K, 48'h3400_0000_0000, 13'h06A8, 13'h1FF8},
    '{sfp_pkg::LEN_96K, 48'h4C00_0000_0000, 13'h0718, 13'h1FF8},
    '{sfp_pkg::LEN_128K, 48'h7C00_0000_0000, 13'h07B8, 13'h1FF8},
    '{sfp_pkg::LEN_CA, 48'h5000_0000_0000, 13'h1800, 13'h1800}};
  localparam logic [2:0] OFFS [4] = '{3'h2, 3'h3, 3'h5, 3'h7};
  logic mclk = 1'b0, nrst = 1'b0, go = 1'b0, slow = 1'b0;
  logic [11:0] len = 12'h000;
  logic [47:0] head = 48'h0;
  logic [4:0] tail = 5'h00, avs_address = 5'h00, res_ca_index;
  logic avs_read = 1'b0, avs_write = 1'b0, got_v, got_e;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hF, res_ctype;
  logic in_valid, in_bit, in_last, in_ready, res_valid, res_err, res_prev_lp, res_int16k, res_fd_ext;
  logic res_rf_active, avs_waitrequest;
  sfp_pkg::sfp_kind_e res_kind;
  sfp_pkg::sfp_core_e res_core;
  sfp_pkg::sfp_rtype_e res_rf_type;
  logic [1:0] res_bw;
  logic [6:0] res_sid_gain;
  logic [36:0] res_sid_env;
  logic [2:0] res_sid_hang, res_rf_offset;
  logic [5:0] res_sid_extra;
  int err_count = 0;
  int total_checks = 0;

  sfp_parser dut_u (.mclk, .nrst, .in_valid, .in_bit, .in_last, .in_ready, .res_valid, .res_err, .res_kind,
    .res_core, .res_bw, .res_ctype, .res_prev_lp, .res_int16k, .res_fd_ext, .res_sid_gain, .res_sid_env,
    .res_sid_hang, .res_sid_extra, .res_ca_index, .res_rf_active, .res_rf_offset, .res_rf_type, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  sfp_src src_u (.mclk, .nrst, .go, .slow, .len, .head, .tail, .in_ready, .in_valid, .in_bit, .in_last);

  always #50 mclk = !mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic [11:0] l, input logic [47:0] h, input logic [4:0] t, input bit run);
    int n;
    @(posedge mclk);
    len <= l;
    head <= h;
    tail <= t;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    got_v = 1'b0;
    got_e = 1'b0;
    for (n = 0; run && n < 3000 && !(got_v || got_e); n++)
    begin
      @(negedge mclk);
      got_v = res_valid;
      got_e = res_err;
    end
    @(negedge mclk);
    if (run)
      chk(res_valid | res_err, 1'b0);
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge mclk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    chk({in_ready, res_valid, res_err}, 3'b100);
    bus(1'b0, sfp_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    $display("test reset done");
    foreach (ROWS[i])
    begin
      frame(ROWS[i].len, ROWS[i].head, 5'h00, 1'b1);
      chk(got_v, 1'b1);
      chk({res_kind, res_core, res_bw, res_ctype, res_prev_lp, res_int16k, res_fd_ext} & ROWS[i].msk, ROWS[i].exp);
    end
    $display("test table done");
    frame(sfp_pkg::LEN_SID, {11'h3D5, 37'h0123456789}, 5'h00, 1'b1);
    chk({res_kind, res_bw, res_int16k, res_sid_gain}, {sfp_pkg::KIND_SID_SPECTRAL, 2'h3, 1'b1, 7'h55});
    chk(res_sid_env, 37'h0123456789);
    frame(sfp_pkg::LEN_SID, {6'h25, 29'h0ABCDEF1, 7'h3C, 6'h2D}, 5'h00, 1'b1);
    chk({res_kind, res_bw, res_int16k, res_sid_hang, res_sid_gain, res_sid_extra},
      {sfp_pkg::KIND_SID_PREDICTIVE, 2'h0, 17'h0AF2D});
    chk(res_sid_env, 37'h00ABCDEF1);
    frame(sfp_pkg::LEN_SID, {6'h3A, 29'h1, 7'h01, 4'h9, 2'h3}, 5'h00, 1'b1);
    chk({res_bw, res_int16k, res_sid_hang, res_sid_gain, res_sid_extra}, {2'h1, 1'b1, 3'h2, 7'h01, 6'h24});
    $display("test descriptor done");
    for (int t = 0; t < 8; t++)
    begin
      slow <= t[0];
      frame(sfp_pkg::LEN_CA, {5'h13, 43'h0}, {t[1:0], t[2:0]}, 1'b1);
      chk({res_kind, res_ca_index, res_rf_active}, {sfp_pkg::KIND_AWARE, 5'h13, 1'b1});
      chk({res_rf_offset, res_rf_type}, {OFFS[t[1:0]], t[2:0]});
    end
    slow <= 1'b0;
    frame(sfp_pkg::LEN_CA, {5'h0A, 43'h0}, 5'h00, 1'b1);
    chk({res_ca_index, res_rf_active, res_rf_offset, res_rf_type}, 12'h500);
    frame(sfp_pkg::LEN_CA, {5'h0A, 43'h0}, 5'h01, 1'b1);
    chk({got_e, got_v}, 2'b10);
    frame(12'h02F, 48'h0, 5'h00, 1'b1);
    chk({got_e, got_v}, 2'b10);
    frame(12'h031, 48'h0, 5'h00, 1'b1);
    chk({got_e, got_v, res_ca_index}, 7'h4A);
    $display("test aware and errors done");
    bus(1'b0, sfp_pkg::REG_LAST, 32'h0);
    chk(rd[11:0], 12'h031);
    bus(1'b0, sfp_pkg::REG_COUNT, 32'h0);
    chk(rd[31:16], 16'h0003);
    bus(1'b1, sfp_pkg::REG_CTRL, 32'h3);
    bus(1'b0, sfp_pkg::REG_COUNT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 5'h10, 32'hFFFF_FFFF);
    bus(1'b0, 5'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, sfp_pkg::REG_CTRL, 32'h0);
    chk(in_ready, 1'b0);
    frame(sfp_pkg::LEN_SID, 48'h0, 5'h00, 1'b0);
    repeat (60) @(negedge mclk);
    chk(res_valid, 1'b0);
    bus(1'b1, sfp_pkg::REG_CTRL, 32'h1);
    repeat (60) @(negedge mclk);
    bus(1'b0, sfp_pkg::REG_COUNT, 32'h0);
    chk(rd[15:0] != 16'h0, 1'b1);
    $display("test registers done");
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    chk({in_ready, res_kind, res_ca_index}, 8'h80);
    $display("test second reset done");
    test_done();
  end

  initial
  begin
    repeat (40000) @(posedge mclk);
    err_count++;
    test_done();
  end
endmodule

`default_nettype wire
